// >>> common/adc_compute_pkg.sv
// Constants, types and register layout of the result computation unit
package adc_compute_pkg;

    // ==========================================================
    // Widths
    localparam int RES_W = 16;
    localparam int ACC_W = 16;
    localparam int TALLY_W = 8;

    // ==========================================================
    // Computation modes
    localparam logic [2:0] MODE_BASIC = 3'h0;
    localparam logic [2:0] MODE_ACCUM = 3'h1;
    localparam logic [2:0] MODE_AVERAGE = 3'h2;
    localparam logic [2:0] MODE_BURST = 3'h3;
    localparam logic [2:0] MODE_LOWPASS = 3'h4;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_TARGET = 8'h08;
    localparam logic [7:0] OFS_TALLY = 8'h0C;
    localparam logic [7:0] OFS_SUM_LOW = 8'h10;
    localparam logic [7:0] OFS_SUM_HIGH = 8'h14;
    localparam logic [7:0] OFS_SCALED = 8'h18;
    localparam logic [7:0] OFS_LOWER = 8'h1C;
    localparam logic [7:0] OFS_UPPER = 8'h20;
    localparam logic [7:0] OFS_EARLIER = 8'h24;
    localparam logic [7:0] OFS_RESULT = 8'h28;

    // ==========================================================
    // Control register fields
    localparam int CTL_MODE_LSB = 0;
    localparam int CTL_DOUBLE_SAMPLE_ENABLE_BIT = 3;
    localparam int CTL_SHIFT_LSB = 4;
    localparam int CTL_LAUNCH_BIT = 8;
    localparam int CTL_CLEAR_BIT = 9;
    localparam int CTL_RCOSC_BIT = 10;

    // Status register fields, write one to clear
    localparam int STS_DONE_BIT = 0;
    localparam int STS_THRESH_BIT = 1;
    localparam int STS_WRAP_BIT = 2;

    // ==========================================================
    // Reset values and cycle counts
    localparam logic [7:0] TARGET_RESET = 8'h01;
    localparam logic [TALLY_W-1:0] TALLY_MAX = 8'hFF;
    localparam logic [2:0] CLEAR_CYCLES_RC = 3'h5;
    localparam logic [2:0] CLEAR_CYCLES_SYS = 3'h1;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CONVERT,
        ST_CLEAR
    } phase_t;

    typedef struct packed {
        logic [2:0] mode;
        logic double_sample_enable;
        logic [2:0] shift;
        logic launch;
        logic clear_req;
        logic rc_osc;
        logic [7:0] target;
        logic signed [RES_W-1:0] lower;
        logic signed [RES_W-1:0] upper;
    } control_t;

    typedef struct packed {
        logic done;
        logic thresh;
        logic wrap;
    } flags_t;

endpackage

// >>> design/adc_result_computation.sv
// Post-conversion computation unit with classic Wishbone register slave
`timescale 1ns/100ps
`default_nettype none

module adc_result_computation #(
    parameter int RES_W = adc_compute_pkg::RES_W,
    parameter int ACC_W = adc_compute_pkg::ACC_W
) (
    input wire logic CLOCK,
    input wire logic NRST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic EXT_TRIGGER,
    input wire logic CONV_READY,
    input wire logic [RES_W-1:0] CONV_RESULT,
    output logic CONV_START,
    output logic DONE_FLAG,
    output logic THRESH_FLAG
);

    // ==========================================================
    // State
    typedef struct packed {
        adc_compute_pkg::phase_t phase;
        adc_compute_pkg::control_t ctl;
        adc_compute_pkg::flags_t flg;
        logic [ACC_W-1:0] sum;
        logic [adc_compute_pkg::TALLY_W-1:0] tally;
        logic [RES_W-1:0] scaled;
        logic [RES_W-1:0] result;
        logic [RES_W-1:0] earlier;
        logic second;
        logic [2:0] clr_cnt;
        logic start;
        logic ack;
        logic [31:0] rdata;
        logic [2:0] trig_sync;
    } state_t;

    state_t q, d;

    // ==========================================================
    // Helpers
    function automatic logic [31:0] merge(input logic [31:0] old,
            input logic [31:0] wr, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = wr[8*i +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [adc_compute_pkg::TALLY_W-1:0] bump(
            input logic [adc_compute_pkg::TALLY_W-1:0] t);
        // Saturate rather than wrap so a long run never looks short
        if (t == adc_compute_pkg::TALLY_MAX) begin
            return t;
        end
        return t + 8'h01;
    endfunction

    function automatic logic [31:0] ctl_word(
            input adc_compute_pkg::control_t c);
        logic [31:0] w;
        w = 32'h0;
        w[adc_compute_pkg::CTL_MODE_LSB +: 3] = c.mode;
        w[adc_compute_pkg::CTL_DOUBLE_SAMPLE_ENABLE_BIT] = c.double_sample_enable;
        w[adc_compute_pkg::CTL_SHIFT_LSB +: 3] = c.shift;
        w[adc_compute_pkg::CTL_LAUNCH_BIT] = c.launch;
        w[adc_compute_pkg::CTL_CLEAR_BIT] = c.clear_req;
        w[adc_compute_pkg::CTL_RCOSC_BIT] = c.rc_osc;
        return w;
    endfunction

    // ==========================================================
    // Next state
    logic bus_req, wr_now, trig, launch_evt, test_now, test_true;
    logic [31:0] wv, rv;
    logic [RES_W-1:0] sample;
    logic [ACC_W:0] wide;
    logic signed [RES_W-1:0] err;

    always_comb begin
        d = q;
        bus_req = WB_CYC_I && WB_STB_I;
        wr_now = bus_req && WB_WE_I && q.ack;
        wv = 32'h0;
        rv = 32'h0;
        launch_evt = 1'b0;
        test_now = 1'b0;
        test_true = 1'b0;
        sample = '0;
        wide = '0;
        err = '0;
        d.start = 1'b0;
        d.ack = bus_req && !q.ack;
        d.trig_sync = {q.trig_sync[1:0], EXT_TRIGGER};
        trig = q.trig_sync[1] && !q.trig_sync[2];

        // ======================================================
        // Register writes, taken at the edge where ack is seen
        if (wr_now) begin
            case (WB_ADR_I)
                adc_compute_pkg::OFS_CONTROL: begin
                    wv = merge(ctl_word(q.ctl), WB_DAT_I, WB_SEL_I);
                    d.ctl.mode = wv[adc_compute_pkg::CTL_MODE_LSB +: 3];
                    d.ctl.double_sample_enable = wv[adc_compute_pkg::CTL_DOUBLE_SAMPLE_ENABLE_BIT];
                    d.ctl.shift = wv[adc_compute_pkg::CTL_SHIFT_LSB +: 3];
                    d.ctl.rc_osc = wv[adc_compute_pkg::CTL_RCOSC_BIT];
                    if (wv[adc_compute_pkg::CTL_LAUNCH_BIT] &&
                            !q.ctl.launch) begin
                        launch_evt = 1'b1;
                    end
                    if (wv[adc_compute_pkg::CTL_CLEAR_BIT] &&
                            q.phase != adc_compute_pkg::ST_CLEAR) begin
                        d.ctl.clear_req = 1'b1;
                    end
                end
                adc_compute_pkg::OFS_STATUS: begin
                    wv = WB_DAT_I & {{24{1'b0}}, {8{WB_SEL_I[0]}}};
                    if (wv[adc_compute_pkg::STS_DONE_BIT]) begin
                        d.flg.done = 1'b0;
                    end
                    if (wv[adc_compute_pkg::STS_THRESH_BIT]) begin
                        d.flg.thresh = 1'b0;
                    end
                    if (wv[adc_compute_pkg::STS_WRAP_BIT]) begin
                        d.flg.wrap = 1'b0;
                    end
                end
                adc_compute_pkg::OFS_TARGET: begin
                    if (WB_SEL_I[0]) begin
                        d.ctl.target = WB_DAT_I[7:0];
                    end
                end
                adc_compute_pkg::OFS_LOWER: begin
                    wv = merge({16'h0, q.ctl.lower}, WB_DAT_I, WB_SEL_I);
                    d.ctl.lower = wv[RES_W-1:0];
                end
                adc_compute_pkg::OFS_UPPER: begin
                    wv = merge({16'h0, q.ctl.upper}, WB_DAT_I, WB_SEL_I);
                    d.ctl.upper = wv[RES_W-1:0];
                end
                default: begin
                end
            endcase
        end
        if (trig && !q.ctl.launch) begin
            launch_evt = 1'b1;
        end

        // ======================================================
        // Sequencer
        case (q.phase)
            adc_compute_pkg::ST_IDLE: begin
                if (q.ctl.clear_req) begin
                    d.phase = adc_compute_pkg::ST_CLEAR;
                    d.clr_cnt = q.ctl.rc_osc ?
                        adc_compute_pkg::CLEAR_CYCLES_RC :
                        adc_compute_pkg::CLEAR_CYCLES_SYS;
                end else if (launch_evt) begin
                    d.ctl.launch = 1'b1;
                    d.start = 1'b1;
                    d.phase = adc_compute_pkg::ST_CONVERT;
                    // Mode written together with the launch rules this step
                    if (d.ctl.mode == adc_compute_pkg::MODE_AVERAGE &&
                            q.tally >= d.ctl.target) begin
                        d.sum = '0;
                        d.tally = '0;
                    end
                    if (d.ctl.mode == adc_compute_pkg::MODE_BURST &&
                            !q.second) begin
                        d.sum = '0;
                        d.tally = '0;
                    end
                end
            end
            adc_compute_pkg::ST_CONVERT: begin
                if (CONV_READY) begin
                    d.phase = adc_compute_pkg::ST_IDLE;
                    d.ctl.launch = 1'b0;
                    d.result = CONV_RESULT;
                    if (q.ctl.double_sample_enable && !q.second) begin
                        // First of a pair stores its value, and raises done only outside basic mode
                        d.second = 1'b1;
                        d.earlier = CONV_RESULT;
                        if (q.ctl.mode != adc_compute_pkg::MODE_BASIC) begin
                            d.flg.done = 1'b1;
                        end
                    end else begin
                        d.second = 1'b0;
                        sample = q.ctl.double_sample_enable ?
                            CONV_RESULT - q.earlier : CONV_RESULT;
                        d.flg.done = 1'b1;
                        case (q.ctl.mode)
                            adc_compute_pkg::MODE_BASIC: begin
                                test_now = 1'b1;
                                err = sample;
                            end
                            adc_compute_pkg::MODE_LOWPASS: begin
                                wide = {1'b0, q.sum} + {1'b0, sample} -
                                    {1'b0, q.sum >> q.ctl.shift};
                            end
                            default: begin
                                wide = {1'b0, q.sum} + {1'b0, sample};
                            end
                        endcase
                        if (q.ctl.mode != adc_compute_pkg::MODE_BASIC) begin
                            d.sum = wide[ACC_W-1:0];
                            if (wide[ACC_W]) begin
                                d.flg.wrap = 1'b1;
                            end
                            d.tally = bump(q.tally);
                            d.scaled = wide[ACC_W-1:0] >> q.ctl.shift;
                            err = d.scaled;
                            if (q.ctl.mode == adc_compute_pkg::MODE_ACCUM) begin
                                test_now = 1'b1;
                            end else begin
                                test_now = d.tally >= q.ctl.target;
                            end
                            if (q.ctl.mode == adc_compute_pkg::MODE_BURST &&
                                    d.tally < q.ctl.target) begin
                                // Burst keeps converting without software
                                d.phase = adc_compute_pkg::ST_CONVERT;
                                d.ctl.launch = 1'b1;
                                d.start = 1'b1;
                                test_now = 1'b0;
                            end
                        end
                    end
                end
            end
            adc_compute_pkg::ST_CLEAR: begin
                d.sum = '0;
                d.tally = '0;
                d.flg.wrap = 1'b0;
                d.clr_cnt = q.clr_cnt - 3'h1;
                if (q.clr_cnt == 3'h1) begin
                    d.ctl.clear_req = 1'b0;
                    d.phase = adc_compute_pkg::ST_IDLE;
                end
            end
            default: begin
                d.phase = adc_compute_pkg::ST_IDLE;
            end
        endcase

        // Signed window test, flagged only when it actually runs
        test_true = (err < q.ctl.lower) || (err > q.ctl.upper);
        if (test_now && test_true) begin
            d.flg.thresh = 1'b1;
        end

        // ======================================================
        // Read data, valid together with ack
        case (WB_ADR_I)
            adc_compute_pkg::OFS_CONTROL: rv = ctl_word(q.ctl);
            adc_compute_pkg::OFS_STATUS: rv = {29'h0, q.flg.wrap,
                q.flg.thresh, q.flg.done};
            adc_compute_pkg::OFS_TARGET: rv = {24'h0, q.ctl.target};
            adc_compute_pkg::OFS_TALLY: rv = {24'h0, q.tally};
            adc_compute_pkg::OFS_SUM_LOW: rv = {24'h0, q.sum[7:0]};
            adc_compute_pkg::OFS_SUM_HIGH: rv = {24'h0, q.sum[15:8]};
            adc_compute_pkg::OFS_SCALED: rv = {16'h0, q.scaled};
            adc_compute_pkg::OFS_LOWER: rv = {16'h0, q.ctl.lower};
            adc_compute_pkg::OFS_UPPER: rv = {16'h0, q.ctl.upper};
            adc_compute_pkg::OFS_EARLIER: rv = {16'h0, q.earlier};
            adc_compute_pkg::OFS_RESULT: rv = {16'h0, q.result};
            default: rv = 32'h0;
        endcase
        d.rdata = (bus_req && !q.ack) ? rv : 32'h0;
    end

    // ==========================================================
    // Registers
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            q <= '0;
            q.phase <= adc_compute_pkg::ST_IDLE;
            q.ctl.target <= adc_compute_pkg::TARGET_RESET;
        end else begin
            q <= d;
        end
    end

    assign WB_DAT_O = q.rdata;
    assign WB_ACK_O = q.ack;
    assign CONV_START = q.start;
    assign DONE_FLAG = q.flg.done;
    assign THRESH_FLAG = q.flg.thresh;

endmodule // adc_result_computation

`default_nettype wire

// >>> test/adc_compute_checker.sv
// Bus, conversion handshake and flag checker for the computation unit
`timescale 1ns/100ps
`default_nettype none
module adc_compute_checker (
    input wire logic CLOCK,
    input wire logic NRST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    input wire logic EXT_TRIGGER,
    input wire logic CONV_READY,
    input wire logic CONV_START,
    input wire logic DONE_FLAG,
    input wire logic THRESH_FLAG
);
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!NRST);
    // ======================================================
    // Helpers
    logic pend_q;
    wire logic go_wr = WB_ACK_O & WB_WE_I & WB_SEL_I[1]
        & (WB_ADR_I == adc_compute_pkg::OFS_CONTROL)
        & WB_DAT_I[adc_compute_pkg::CTL_LAUNCH_BIT];
    wire logic sts_wr = WB_ACK_O & WB_WE_I
        & (WB_ADR_I == adc_compute_pkg::OFS_STATUS);
    // Idle unknown at the ports, so track the outstanding conversion
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            pend_q <= 1'b0;
        end else begin
            pend_q <= CONV_START | (pend_q & ~CONV_READY);
        end
    end
    // ======================================================
    // Assertions
    AST_ACK_ANSWER: assert property (
        WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("ack missing after request");
    AST_ACK_PULSE: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    AST_DAT_IDLE: assert property (
        !WB_ACK_O |-> WB_DAT_O == 32'h0)
        else $error("read data outside ack");
    AST_LAUNCH: assert property (
        go_wr && !pend_q && !CONV_START |-> ##[1:2] CONV_START)
        else $error("launch write gave no start");
    AST_EXT_START: assert property (
        $rose(EXT_TRIGGER) && !pend_q && !CONV_START |-> ##[2:6] CONV_START)
        else $error("external trigger gave no start");
    AST_START_PULSE: assert property (CONV_START |=> !CONV_START)
        else $error("start longer than one cycle");
    AST_ONE_OUT: assert property (CONV_START |-> !pend_q)
        else $error("second start while converting");
    AST_DONE_CAUSE: assert property (
        $rose(DONE_FLAG) |-> $past(CONV_READY))
        else $error("done rose without a result");
    AST_THR_CAUSE: assert property (
        $rose(THRESH_FLAG) |-> $past(CONV_READY))
        else $error("threshold rose without a test");
    AST_DONE_HOLD: assert property (
        DONE_FLAG && !sts_wr |=> DONE_FLAG)
        else $error("done dropped without a clear");
    cover property (go_wr ##[1:2] CONV_START);
    cover property ($rose(EXT_TRIGGER) ##[2:6] CONV_START);
    cover property (CONV_READY ##1 CONV_START);
    cover property ($rose(THRESH_FLAG));
endmodule // adc_compute_checker
`default_nettype wire

// >>> test/conv_core_model.sv
// Behavioural conversion core answering start pulses with results
`timescale 1ns/100ps
`default_nettype none
module conv_core_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic start,
    input wire logic [3:0] lat,
    input wire logic [15:0] value,
    output logic ready,
    output logic [15:0] result
);
    logic busy;
    logic [3:0] cnt;
    logic [15:0] last;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            busy <= 1'b0;
            cnt <= 4'h0;
            ready <= 1'b0;
            result <= 16'h0;
            last <= 16'h0;
        end else begin
            ready <= 1'b0;
            // Stale bus shows the inverse so a late sample cannot pass
            result <= ~last;
            if (start) begin
                busy <= 1'b1;
                cnt <= lat;
            end else if (busy && cnt <= 4'h1) begin
                busy <= 1'b0;
                ready <= 1'b1;
                result <= value;
                last <= value;
            end else if (busy) begin
                cnt <= cnt - 4'h1;
            end
        end
    end
endmodule // conv_core_model
`default_nettype wire

// >>> test/testbench.sv
// Self-checking bench for the result computation unit
`timescale 1ns/100ps
`default_nettype none
module testbench;
    // ======================================================
    // Stimulus, partner and design
    logic clock = 1'b0, nrst = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic ext_trig = 1'b0, ack, ready, start, done_f, thr_f, wrap;
    logic [7:0] adr = 8'h00, tally;
    logic [3:0] sel = 4'h0, lat = 4'h1;
    logic [31:0] wdat = 32'h0, rdat, c, ew;
    logic [15:0] value = 16'h0, result, sum, v;
    logic signed [15:0] lo, up;
    logic [31:0] exp_q[$];
    string name_q[$];
    int bad_count, comparisons, cycles, readies, i, k;
    always #50 clock = ~clock;
    adc_result_computation uut (.CLOCK(clock), .NRST(nrst), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
        .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .EXT_TRIGGER(ext_trig), .CONV_READY(ready), .CONV_RESULT(result),
        .CONV_START(start), .DONE_FLAG(done_f), .THRESH_FLAG(thr_f));
    conv_core_model core (.clk(clock), .nrst(nrst), .start(start),
        .lat(lat), .value(value), .ready(ready), .result(result));
    // ======================================================
    // Tasks
    task automatic summarize;
        if (bad_count == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic check(string n, logic [31:0] s, logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wb(logic [7:0] a, logic w, logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        do begin
            @(posedge clock);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20) bad_count++;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] e, string n);
        exp_q.push_back(e);
        name_q.push_back(n);
        wb(a, 1'b0, 32'h0);
    endtask
    function automatic logic [31:0] cf(logic [2:0] m, d, s);
        return {21'h0, 4'h8, s, d[0], m};
    endfunction
    function automatic logic hit(logic [15:0] e);
        return ($signed(e) < lo) || ($signed(e) > up);
    endfunction
    task automatic wait_rdy(int n);
        repeat (60) if (readies < n) @(posedge clock);
    endtask
    task automatic conv(logic [15:0] s, int n, logic [31:0] m);
        int t;
        t = readies + n;
        wb(adc_compute_pkg::OFS_STATUS, 1'b1, 32'h3);
        value <= s;
        lat <= 4'($urandom_range(7, 1));
        wb(adc_compute_pkg::OFS_CONTROL, 1'b1, m | 32'h100);
        wait_rdy(t);
        repeat (2) @(posedge clock);
    endtask
    task automatic add(logic [15:0] s);
        logic cy;
        {cy, sum} = {1'b0, sum} + {1'b0, s};
        wrap = wrap | cy;
        tally = (tally == 8'hFF) ? tally : tally + 8'h01;
    endtask
    task automatic thr(logic [15:0] l, logic [15:0] u);
        lo = l;
        up = u;
        wb(adc_compute_pkg::OFS_LOWER, 1'b1, {16'h0, l});
        wb(adc_compute_pkg::OFS_UPPER, 1'b1, {16'h0, u});
    endtask
    task automatic clr(logic [31:0] m);
        wb(adc_compute_pkg::OFS_CONTROL, 1'b1, m | 32'h200);
        rd(adc_compute_pkg::OFS_CONTROL, m | 32'h200, "clearing");
        // Still busy four edges into the clear, gone one read later
        rd(adc_compute_pkg::OFS_CONTROL, m | 32'h200, "still_clr");
        rd(adc_compute_pkg::OFS_CONTROL, m, "cleared");
        sum = 16'h0;
        tally = 8'h0;
        wrap = 1'b0;
    endtask
    task automatic state(logic [2:0] sh, logic t, logic lp);
        logic [15:0] f;
        f = sum >> sh;
        rd(adc_compute_pkg::OFS_TALLY, {24'h0, tally}, "tally");
        rd(adc_compute_pkg::OFS_SUM_LOW, {24'h0, sum[7:0]}, "sum_lo");
        rd(adc_compute_pkg::OFS_SUM_HIGH, {24'h0, sum[15:8]}, "sum_hi");
        if (!lp) rd(adc_compute_pkg::OFS_SCALED, {16'h0, f}, "scaled");
        rd(adc_compute_pkg::OFS_STATUS, {29'h0, wrap, t && hit(f), 1'b1},
            "status");
    endtask
    // ======================================================
    // Result watcher and timeout
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (ready === 1'b1) readies <= readies + 1;
        if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
            ew = exp_q.pop_front();
            check(name_q.pop_front(), rdat, ew);
            if (adr == adc_compute_pkg::OFS_STATUS) begin
                // Flag pins must agree with the expected status bits
                check("pins", {30'h0, thr_f, done_f}, ew & 32'h3);
            end
        end
        if (cycles == 20000) begin
            bad_count++;
            summarize();
        end
    end
    // ======================================================
    // Scenarios
    initial begin
        k = $urandom(32'h9DFFFB2D);
        repeat (12) @(posedge clock);
        nrst <= 1'b1;
        rd(adc_compute_pkg::OFS_CONTROL, 32'h0, "control");
        rd(adc_compute_pkg::OFS_TARGET, 32'h1, "target");
        rd(adc_compute_pkg::OFS_STATUS, 32'h0, "status0");
        wb(8'h3C, 1'b1, 32'hFFFFFFFF);
        rd(8'h3C, 32'h0, "unmapped");
        sum = 16'h0;
        tally = 8'h0;
        wrap = 1'b0;
        thr(16'h0000, 16'h0000);
        c = cf(adc_compute_pkg::MODE_ACCUM, 0, 2);
        for (i = 0; i < 5; i++) begin
            v = (i == 4) ? 16'hFFFF : 16'($urandom_range(16'h3FFF, 1));
            conv(v, 1, c);
            add(v);
            state(2, 1'b1, 1'b0);
        end
        wb(adc_compute_pkg::OFS_TARGET, 1'b1, 32'h2);
        c = cf(adc_compute_pkg::MODE_AVERAGE, 0, 1);
        clr(c);
        for (i = 0; i < 3; i++) begin
            v = 16'($urandom_range(400, 1));
            conv(v, 1, c);
            if (tally >= 8'h2) {sum, tally} = 24'h0;
            add(v);
            state(1, tally >= 8'h2, 1'b0);
        end
        wb(adc_compute_pkg::OFS_TARGET, 1'b1, 32'h3);
        for (i = 0; i < 2; i++) begin
            conv(16'h0021, 3, cf(adc_compute_pkg::MODE_BURST, 0, 1));
            sum = 16'h0063;
            tally = 8'h3;
            state(1, 1'b1, 1'b0);
        end
        c = cf(adc_compute_pkg::MODE_LOWPASS, 0, 2);
        clr(c);
        thr(16'h8000, 16'h0010);
        for (i = 0; i < 3; i++) begin
            v = 16'($urandom_range(2000, 1));
            conv(v, 1, c);
            sum = v + sum - (sum >> 2);
            tally = tally + 8'h01;
            state(2, tally >= 8'h3, 1'b1);
        end
        thr(16'hFFF8, 16'h0064);
        c = cf(adc_compute_pkg::MODE_BASIC, 1, 0);
        conv(16'h0014, 1, c);
        rd(adc_compute_pkg::OFS_STATUS, 32'h0, "first_half");
        conv(16'h0010, 1, c);
        rd(adc_compute_pkg::OFS_EARLIER, 32'h14, "earlier");
        rd(adc_compute_pkg::OFS_RESULT, 32'h10, "result");
        rd(adc_compute_pkg::OFS_STATUS, 32'h1, "signed_diff");
        c = cf(adc_compute_pkg::MODE_BASIC, 0, 0);
        conv(16'hFFF0, 1, c);
        rd(adc_compute_pkg::OFS_STATUS, 32'h3, "below_low");
        conv(16'h0005, 1, c);
        rd(adc_compute_pkg::OFS_STATUS, 32'h1, "inside");
        rd(adc_compute_pkg::OFS_TALLY, {24'h0, tally}, "basic_tally");
        value <= 16'h0042;
        k = readies + 1;
        ext_trig <= 1'b1;
        wait_rdy(k);
        ext_trig <= 1'b0;
        rd(adc_compute_pkg::OFS_RESULT, 32'h42, "ext_result");
        c = cf(adc_compute_pkg::MODE_ACCUM, 0, 0);
        clr(c);
        for (i = 0; i < 256; i++) begin
            conv(16'h0000, 1, c);
            add(16'h0000);
        end
        state(0, 1'b1, 1'b0);
        summarize();
    end
endmodule // testbench
bind adc_result_computation adc_compute_checker chk (.CLOCK(CLOCK),
    .NRST(NRST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
    .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
    .EXT_TRIGGER(EXT_TRIGGER), .CONV_READY(CONV_READY),
    .CONV_START(CONV_START), .DONE_FLAG(DONE_FLAG),
    .THRESH_FLAG(THRESH_FLAG));
`default_nettype wire
